// File: design/aca_top.sv
/*
 Setup decoder and digital alert comparator of a small converter.
 Assumes a two-wire bus controller on mclk that presents decoded register
 pointer, write and read strobes, and an analog core with its own sample
 clock that holds each result steady for at least one of its periods.
*/
// Contract
// - Select field 14:12 pairs inputs, differential for codes 0-3, single-ended to ground for 4-7.
// - Gain field 11:9 picks full-scale range.
// - Mode bit 8: continuous or single shot.
// - Rate field 7:5 decodes sample rate.
// - Bit 4 picks traditional or window comparator.
// - Bit 3 sets asserted alert pin level.
// - Unlatched alert clears once results return.
// - Latched alert held until read or response.
// - Alert response replies with own address.
// - Queue code 11 disables comparator, floats pin.
// - Queue needs one, two or four hits.
// - Trigger bit starts conversion, reads idle status.
// - Limit sign bits select ready signalling.
// - Limits are signed sixteen-bit values; writes keep bits 15:4 and bits 3:0 are held at zero.
`timescale 1ns/1ps

`include "aca_consts.svh"

module aca_top
   import aca_pkg::*;
#(
   parameter int RDY_CYC =
      (`RDY_PULSE_NS * `MCLK_MHZ + 999) / 1000
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Register port from the bus controller
   input  wire logic [1:0]  reg_ptr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   // Alert response
   input  wire logic        ara_req,
   input  wire logic        ara_won,
   input  wire logic [6:0]  dev_addr,
   output logic             ara_ack,
   output logic      [6:0]  ara_addr,
   // Analog core
   input  wire logic        ana_clk,
   input  wire logic        ana_done,
   input  wire logic [15:0] ana_result,
   output logic             conv_start,
   output logic             conv_run,
   output logic      [1:0]  pos_input,
   output logic      [2:0]  neg_input,
   output logic      [12:0] fsr_mv,
   output logic      [11:0] rate_sps,
   // Alert pin
   output logic             alert_o,
   output logic             alert_oe_n
);

   aca_state_s q;
   aca_state_s d;
   logic [1:0] ana_s;
   logic       new_res;
   logic       wr_cfg;
   logic       rd_res;
   logic       above;
   logic       below;
   logic       hit;
   logic       q_reached;
   logic       set_alert;
   logic       clr_alert;
   logic       rdy_mode;
   logic       act;

   if (RDY_CYC < 1 || RDY_CYC >= (1 << `RDY_CNT_W)) begin : g_bad_rdy
      $error("aca_top ready pulse length out of range");
   end

   function automatic logic [4:0] pair_decode(input logic [2:0] sel);
      if (sel[2]) begin
         pair_decode = {sel[1:0], `NEG_GND};
      end else if (sel == 3'h0) begin
         pair_decode = {2'h0, `NEG_IN1};
      end else begin
         pair_decode = {2'(sel - 3'h1), `NEG_IN3};
      end
   endfunction

   function automatic logic [12:0] fsr_decode(input logic [2:0] g);
      unique case (g)
         3'h0:    fsr_decode = `FSR_6144;
         3'h1:    fsr_decode = `FSR_4096;
         3'h2:    fsr_decode = `FSR_2048;
         3'h3:    fsr_decode = `FSR_1024;
         3'h4:    fsr_decode = `FSR_0512;
         default: fsr_decode = `FSR_0256;
      endcase
   endfunction

   function automatic logic [11:0] rate_decode(input logic [2:0] r);
      unique case (r)
         3'h0:    rate_decode = `SPS_128;
         3'h1:    rate_decode = `SPS_250;
         3'h2:    rate_decode = `SPS_490;
         3'h3:    rate_decode = `SPS_920;
         3'h4:    rate_decode = `SPS_1600;
         3'h5:    rate_decode = `SPS_2400;
         default: rate_decode = `SPS_3300;
      endcase
   endfunction

   // The sample clock is only looked at after the synchroniser settles.
   aca_sync3 #(
      .W (2)
   ) u_sync (
      .mclk     (mclk),
      .rst      (rst),
      .async_in ({ana_done, ana_clk}),
      .sync_out (ana_s)
   );

   aca_queue #(
      .CNT_W (3)
   ) u_queue (
      .mclk     (mclk),
      .rst      (rst),
      .tick     (new_res),
      .hit      (hit),
      .que_code (q.que),
      .reached  (q_reached)
   );

   assign new_res = ana_s[0] && !q.clk_prev && ana_s[1];
   assign wr_cfg  = reg_wr && (reg_ptr == `PTR_CONFIG);
   assign rd_res  = reg_rd && (reg_ptr == `PTR_RESULT);
   assign above   = $signed(ana_result) > $signed(q.upper);
   assign below   = $signed(ana_result) < $signed(q.lower);
   assign hit     = q.win ? (above || below) : above;

   // The run counter lags a result by a cycle, so judging waits for eval.
   assign set_alert = q.eval && q_reached;
   assign clr_alert = (q.eval && !q.lat &&
                       (q.win ? !q.last_hit : q.last_below))
                   || (q.lat && (rd_res || ara_won));

   always_comb begin
      d          = q;
      d.start    = 1'b0;
      d.ack      = 1'b0;
      d.rvalid   = 1'b0;
      d.eval     = 1'b0;
      d.clk_prev = ana_s[0];
      rdy_mode   = 1'b0;
      act        = 1'b0;
      if (wr_cfg) begin
         d.in_sel = reg_wdata[`F_SEL_HI:`F_SEL_LO];
         d.gain   = reg_wdata[`F_GAIN_HI:`F_GAIN_LO];
         d.mode   = reg_wdata[`F_MODE];
         d.rate   = reg_wdata[`F_RATE_HI:`F_RATE_LO];
         d.win    = reg_wdata[`F_WIN];
         d.pol    = reg_wdata[`F_POL];
         d.lat    = reg_wdata[`F_LAT];
         d.que    = reg_wdata[`F_QUE_HI:`F_QUE_LO];
      end
      if (reg_wr && reg_ptr == `PTR_LOWER) begin
         d.lower = {reg_wdata[15:`F_LIM_LO], `LIM_RSVD};
      end
      if (reg_wr && reg_ptr == `PTR_UPPER) begin
         d.upper = {reg_wdata[15:`F_LIM_LO], `LIM_RSVD};
      end
      unique case (q.conv)
         st_down: begin
            if (d.mode == `MODE_CONT) begin
               d.conv = st_cont;
            end else if (wr_cfg && reg_wdata[`F_TRIG]) begin
               d.conv  = st_single;
               d.start = 1'b1;
            end
         end
         st_single: begin
            if (new_res) begin
               d.conv = st_down;
            end
         end
         st_cont: begin
            if (d.mode == `MODE_SINGLE) begin
               d.conv = st_down;
            end
         end
         default: d.conv = st_down;
      endcase
      if (d.rdy_cnt != '0) begin
         d.rdy_cnt = q.rdy_cnt - `RDY_CNT_W'(1);
      end
      if (new_res) begin
         d.result     = ana_result;
         d.last_hit   = hit;
         d.last_below = below;
         d.eval       = 1'b1;
         if (q.conv == st_cont) begin
            d.rdy_cnt = `RDY_CNT_W'(RDY_CYC);
         end
      end
      if (d.que == `QUE_OFF) begin
         d.alert = 1'b0;
      end else if (set_alert) begin
         d.alert = 1'b1;
      end else if (clr_alert) begin
         d.alert = 1'b0;
      end
      if (ara_req && q.alert) begin
         d.ack      = 1'b1;
         d.ara_addr = dev_addr;
      end
      if (reg_rd) begin
         d.rvalid = 1'b1;
         unique case (reg_ptr)
            `PTR_RESULT: d.rdata = q.result;
            `PTR_CONFIG: d.rdata = {q.conv == st_down, q.in_sel, q.gain,
                                    q.mode, q.rate, q.win, q.pol, q.lat,
                                    q.que};
            `PTR_LOWER:  d.rdata = q.lower;
            default:     d.rdata = q.upper;
         endcase
      end
      {d.pos, d.neg} = pair_decode(d.in_sel);
      d.full_scale_range          = fsr_decode(d.gain);
      d.sps          = rate_decode(d.rate);
      rdy_mode = d.upper[`F_SIGN] && !d.lower[`F_SIGN];
      if (rdy_mode) begin
         act = (d.mode == `MODE_SINGLE) ? (d.conv == st_down)
                                        : (d.rdy_cnt != '0);
      end else begin
         act = d.alert;
      end
      d.pin  = d.pol ? act : !act;
      d.oe_n = (d.que == `QUE_OFF);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q        <= '0;
         q.in_sel <= `RST_SEL;
         q.gain   <= `RST_GAIN;
         q.mode   <= `RST_MODE;
         q.rate   <= `RST_RATE;
         q.win    <= `RST_WIN;
         q.pol    <= `RST_POL;
         q.lat    <= `RST_LAT;
         q.que    <= `RST_QUE;
         q.lower  <= `RST_LOWER;
         q.upper  <= `RST_UPPER;
         q.conv   <= st_down;
         q.neg    <= `NEG_IN1;
         q.full_scale_range    <= `FSR_2048;
         q.sps    <= `SPS_1600;
         q.pin    <= 1'b1;
         q.oe_n   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata  = q.rdata;
   assign reg_rvalid = q.rvalid;
   assign ara_ack    = q.ack;
   assign ara_addr   = q.ara_addr;
   assign conv_start = q.start;
   assign conv_run   = (q.conv != st_down);
   assign pos_input  = q.pos;
   assign neg_input  = q.neg;
   assign fsr_mv     = q.full_scale_range;
   assign rate_sps   = q.sps;
   assign alert_o    = q.pin;
   assign alert_oe_n = q.oe_n;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_trigger_write;
      wr_cfg && reg_wdata[`F_TRIG] && reg_wdata[`F_MODE]
      && (q.conv == st_down);
   endsequence

   a_trig_start: assert property (
      s_trigger_write |=> conv_start && conv_run ##1 !conv_start)
      else $error("trigger write did not start one conversion");

   a_trig_read: assert property (
      reg_rd && (reg_ptr == `PTR_CONFIG)
      |=> reg_rvalid && (reg_rdata[`F_TRIG] == !$past(conv_run)))
      else $error("trigger status read back wrong");

   a_queue_off: assert property (
      (q.que == `QUE_OFF) |-> alert_oe_n && !q.alert)
      else $error("alert pin not floated with queue off");

   a_pol_level: assert property (
      !alert_oe_n && !(q.upper[`F_SIGN] && !q.lower[`F_SIGN])
      |-> alert_o == (q.alert ? q.pol : !q.pol))
      else $error("alert pin level does not follow polarity");

   a_latch_hold: assert property (
      q.lat && q.alert && !rd_res && !ara_won && !reg_wr
      |=> q.alert)
      else $error("latched alert dropped without a clear");

   a_latch_clear: assert property (
      q.lat && q.alert && rd_res && !set_alert && !reg_wr
      |=> !q.alert)
      else $error("result read did not clear latched alert");

   a_ara_reply: assert property (
      ara_req && q.alert |=> ara_ack && (ara_addr == $past(dev_addr)))
      else $error("alert response did not return the address");

   a_pair_diff: assert property (
      !q.in_sel[2] && (q.in_sel != 3'h0)
      |-> (neg_input == `NEG_IN3) && (pos_input == 2'(q.in_sel - 3'h1)))
      else $error("differential pair decoded wrong");

   a_pair_single: assert property (
      q.in_sel[2] |-> (neg_input == `NEG_GND)
                      && (pos_input == q.in_sel[1:0]))
      else $error("single-ended input decoded wrong");

   a_fsr_low: assert property (
      (q.gain >= 3'h5) |-> (fsr_mv == `FSR_0256))
      else $error("upper gain codes not at smallest range");

   a_rate_top: assert property (
      (q.rate >= 3'h6) |-> (rate_sps == `SPS_3300))
      else $error("top rate codes not at fastest rate");

   a_win_release: assert property (
      q.eval && !q.lat && q.win && !q.last_hit && !q_reached
      && (q.que != `QUE_OFF) && !reg_wr |=> !q.alert)
      else $error("unlatched window alert not released");

   a_rdy_busy: assert property (
      q.upper[`F_SIGN] && !q.lower[`F_SIGN] && !alert_oe_n
      && (q.mode == `MODE_SINGLE) && (q.conv == st_single)
      |-> alert_o == !q.pol)
      else $error("ready signalling wrong during conversion");

endmodule

// File: design/aca_consts.svh
/*
 Named constants of the converter setup and alert comparator block:
 register pointers, field positions, reset values, decode tables and
 timing. Assumes it is included by bare name and may be seen twice.
*/
`ifndef ACA_CONSTS_SVH
`define ACA_CONSTS_SVH

// Register pointers.
`define PTR_RESULT    2'h0
`define PTR_CONFIG    2'h1
`define PTR_LOWER     2'h2
`define PTR_UPPER     2'h3

// Setup word field positions.
`define F_TRIG        15
`define F_SEL_HI      14
`define F_SEL_LO      12
`define F_GAIN_HI     11
`define F_GAIN_LO     9
`define F_MODE        8
`define F_RATE_HI     7
`define F_RATE_LO     5
`define F_WIN         4
`define F_POL         3
`define F_LAT         2
`define F_QUE_HI      1
`define F_QUE_LO      0
`define F_LIM_LO      4
`define F_SIGN        15

// Reset values.
`define RST_SEL       3'h0
`define RST_GAIN      3'h2
`define RST_MODE      1'h1
`define RST_RATE      3'h4
`define RST_WIN       1'h0
`define RST_POL       1'h0
`define RST_LAT       1'h0
`define RST_QUE       2'h3
`define RST_LOWER     16'h8000
`define RST_UPPER     16'h7ff0
`define LIM_RSVD      4'h0

// Mode and queue codes.
`define MODE_CONT     1'h0
`define MODE_SINGLE   1'h1
`define QUE_ONE       2'h0
`define QUE_TWO       2'h1
`define QUE_FOUR      2'h2
`define QUE_OFF       2'h3
`define NEED_ONE      3'h1
`define NEED_TWO      3'h2
`define NEED_FOUR     3'h4
`define NEED_NONE     3'h0

// Input pair decode.
`define NEG_IN1       3'h1
`define NEG_IN3       3'h3
`define NEG_GND       3'h4

// Full-scale range in millivolts.
`define FSR_6144      13'h1800
`define FSR_4096      13'h1000
`define FSR_2048      13'h0800
`define FSR_1024      13'h0400
`define FSR_0512      13'h0200
`define FSR_0256      13'h0100

// Sample rates in samples per second.
`define SPS_128       12'h080
`define SPS_250       12'h0fa
`define SPS_490       12'h1ea
`define SPS_920       12'h398
`define SPS_1600      12'h640
`define SPS_2400      12'h960
`define SPS_3300      12'hce4

// Ready pulse timing.
`define MCLK_MHZ      100
`define RDY_PULSE_NS  1000
`define RDY_CNT_W     12

`endif

// File: design/aca_pkg.sv
/*
 Types of the converter setup and alert comparator block.
 Assumes the constants header is available on the include path.
*/
`include "aca_consts.svh"

package aca_pkg;

   typedef enum logic [1:0] {
      st_down   = 2'h0,
      st_single = 2'h1,
      st_cont   = 2'h2
   } aca_conv_e;

   typedef struct packed {
      logic [2:0]            in_sel;
      logic [2:0]            gain;
      logic                  mode;
      logic [2:0]            rate;
      logic                  win;
      logic                  pol;
      logic                  lat;
      logic [1:0]            que;
      logic [15:0]           lower;
      logic [15:0]           upper;
      logic [15:0]           result;
      aca_conv_e             conv;
      logic                  alert;
      logic                  eval;
      logic                  last_hit;
      logic                  last_below;
      logic                  clk_prev;
      logic [`RDY_CNT_W-1:0] rdy_cnt;
      logic [15:0]           rdata;
      logic                  rvalid;
      logic                  start;
      logic                  ack;
      logic [6:0]            ara_addr;
      logic [1:0]            pos;
      logic [2:0]            neg;
      logic [12:0]           full_scale_range;
      logic [11:0]           sps;
      logic                  pin;
      logic                  oe_n;
   } aca_state_s;

endpackage

// File: design/aca_sync3.sv
/*
 Three-stage synchroniser for levels from another clock domain.
 A bit changes at the output once the second and third stages agree.
 Assumes the inputs are plain levels with no timing relation to mclk.
*/
`timescale 1ns/1ps

module aca_sync3 #(
   parameter int W = 2
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } aca_sync_s;

   aca_sync_s q;
   aca_sync_s d;

   if (W < 1) begin : g_bad_width
      $error("aca_sync3 needs at least one bit");
   end

   always_comb begin
      d    = q;
      d.s1 = async_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.o  = (q.s2 & ~(q.s2 ^ q.s3)) | (q.o & (q.s2 ^ q.s3));
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.o;

endmodule

// File: design/aca_queue.sv
/*
 Run counter of successive out-of-limit results for the alert queue.
 Assumes tick is a one-cycle pulse per new result on the same clock.
*/
`timescale 1ns/1ps

`include "aca_consts.svh"

module aca_queue #(
   parameter int CNT_W = 3
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Result events
   input  wire logic       tick,
   input  wire logic       hit,
   input  wire logic [1:0] que_code,
   // Run length reached
   output logic            reached
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } aca_queue_s;

   aca_queue_s       q;
   aca_queue_s       d;
   logic [CNT_W-1:0] need;

   if (CNT_W < 3) begin : g_bad_width
      $error("aca_queue counter too narrow for a run of four");
   end

   function automatic logic [2:0] run_need(input logic [1:0] code);
      unique case (code)
         `QUE_ONE:  run_need = `NEED_ONE;
         `QUE_TWO:  run_need = `NEED_TWO;
         `QUE_FOUR: run_need = `NEED_FOUR;
         default:   run_need = `NEED_NONE;
      endcase
   endfunction

   assign need = CNT_W'(run_need(que_code));

   always_comb begin
      d = q;
      if (que_code == `QUE_OFF) begin
         d.cnt = '0;
      end else if (tick && !hit) begin
         d.cnt = '0;
      end else if (tick && q.cnt < need) begin
         d.cnt = q.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign reached = (que_code != `QUE_OFF) && (q.cnt >= need);

   a_run_four: assert property (@(posedge mclk) disable iff (rst)
      (que_code == `QUE_FOUR) && tick && hit && (q.cnt == CNT_W'(3))
      |=> reached)
      else $error("run of four did not reach the queue");

   a_miss_clears: assert property (@(posedge mclk) disable iff (rst)
      (que_code != `QUE_ONE) && tick && !hit && $stable(que_code)
      |=> !reached)
      else $error("a miss did not restart the run");

endmodule

// File: bench/aca_core_model.sv
/*
 Behavioural analog core facing the setup and alert block.
 Assumes conv_run comes from the block and value from the bench.
*/
`timescale 1ns/1ps

module aca_core_model (
   // Control
   input  wire logic        conv_run,
   input  wire logic [15:0] value,
   // Core outputs
   output logic             ana_clk,
   output logic             ana_done,
   output logic      [15:0] ana_result
);
   int unsigned rises;

   // The sample clock stands still between conversions, and the idle
   // result bus toggles so that a stale sample never looks valid.
   initial begin
      ana_clk    = 1'b0;
      ana_done   = 1'b0;
      ana_result = 16'h0000;
      rises      = 0;
      forever begin
         #80;
         if (conv_run) begin
            ana_clk = ~ana_clk;
            if (ana_clk) begin
               rises++;
            end else begin
               ana_done   = (rises >= 2);
               ana_result = value;
            end
         end else begin
            ana_clk    = 1'b0;
            ana_done   = 1'b0;
            rises      = 0;
            ana_result = ~ana_result;
         end
      end
   end
endmodule

// File: bench/tb_top.sv
/*
 Self-checking bench of the setup decoder and alert comparator.
 Assumes the design files and the analog core model are compiled first.
*/
`timescale 1ns/1ps

`include "aca_consts.svh"

module tb_top;
   import aca_pkg::*;

   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  reg_ptr = 2'h0;
   logic        reg_wr = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_rd = 1'b0;
   logic        ara_req = 1'b0;
   logic        ara_won = 1'b0;
   logic [6:0]  dev_addr = 7'h00;
   logic [15:0] core_val = 16'h0000;
   logic [15:0] reg_rdata, ana_result, word, hi_val, lo_val;
   logic        reg_rvalid, ara_ack, ana_clk, ana_done;
   logic        conv_start, conv_run, alert_o, alert_oe_n;
   logic [6:0]  ara_addr;
   logic [1:0]  pos_input;
   logic [2:0]  neg_input, s;
   logic [12:0] fsr_mv;
   logic [11:0] rate_sps;
   int          failures = 0;
   int          tests_run = 0;
   int          k;

   aca_top #(.RDY_CYC(4)) DUT (
      .mclk, .rst, .reg_ptr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
      .reg_rvalid, .ara_req, .ara_won, .dev_addr, .ara_ack, .ara_addr,
      .ana_clk, .ana_done, .ana_result, .conv_start, .conv_run,
      .pos_input, .neg_input, .fsr_mv, .rate_sps, .alert_o, .alert_oe_n
   );

   aca_core_model core (
      .conv_run, .value(core_val), .ana_clk, .ana_done, .ana_result
   );

   always #5 mclk = ~mclk;

   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [1:0] p, input logic [15:0] d);
      @(posedge mclk);
      reg_ptr   <= p;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [1:0] p, output logic [15:0] d);
      @(posedge mclk);
      reg_ptr <= p;
      reg_rd  <= 1'b1;
      @(posedge mclk);
      reg_rd  <= 1'b0;
      #1;
      for (k = 0; k < 2 && reg_rvalid !== 1'b1; k++) cyc(1);
      chk("rvalid", 16'h0001, 16'(reg_rvalid));
      d = reg_rdata;
   endtask

   // Sel 0, gain 2 and rate 4 stay fixed while the alert is exercised.
   task automatic wcfg(input logic m, input logic w, input logic p,
                       input logic l, input logic [1:0] q);
      wr(`PTR_CONFIG, {1'b0, 3'h0, 3'h2, m, 3'h4, w, p, l, q});
   endtask

   task automatic ex(input logic [15:0] v, input int n, input logic on,
                     input logic pol);
      core_val <= v;
      cyc(n);
      chk("alert_oe_n", 16'h0000, 16'(alert_oe_n));
      chk("alert_o", {15'h0000, ~(on ^ pol)}, 16'(alert_o));
   endtask

   function automatic logic [4:0] exp_in(input logic [2:0] x);
      if (x == 3'h0) return {2'h0, `NEG_IN1};
      if (x < 3'h4) return {x[1:0] - 2'h1, `NEG_IN3};
      return {x[1:0], `NEG_GND};
   endfunction

   function automatic logic [12:0] exp_fsr(input logic [2:0] x);
      case (x)
         3'h0: return `FSR_6144;
         3'h1: return `FSR_4096;
         3'h2: return `FSR_2048;
         3'h3: return `FSR_1024;
         3'h4: return `FSR_0512;
         default: return `FSR_0256;
      endcase
   endfunction

   function automatic logic [11:0] exp_sps(input logic [2:0] x);
      case (x)
         3'h0: return `SPS_128;
         3'h1: return `SPS_250;
         3'h2: return `SPS_490;
         3'h3: return `SPS_920;
         3'h4: return `SPS_1600;
         3'h5: return `SPS_2400;
         default: return `SPS_3300;
      endcase
   endfunction

   task automatic summarize;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // About eight times the length of the whole sequence.
   initial begin
      #100000;
      failures++;
      summarize();
   end

   initial begin
      void'($urandom(32'h3f4f));
      hi_val = 16'h0110 + 16'($urandom_range(0, 255)) * 16'h0010;
      lo_val = 16'hfef0 - 16'($urandom_range(0, 255)) * 16'h0010;
      cyc(9);
      @(posedge mclk);
      rst      <= 1'b0;
      dev_addr <= 7'($urandom);
      cyc(1);
      chk("oe_rst", 16'h0001, 16'(alert_oe_n));
      chk("fsr_rst", 16'(`FSR_2048), 16'(fsr_mv));
      chk("sps_rst", 16'(`SPS_1600), 16'(rate_sps));
      rd(`PTR_CONFIG, word);
      chk("setup_rst", 16'h8583, word);
      for (int i = 0; i < 8; i++) begin
         s = 3'(i);
         wr(`PTR_CONFIG, {1'b0, s, s, 1'b1, s, 5'h03});
         cyc(2);
         chk("in", 16'(exp_in(s)), 16'({pos_input, neg_input}));
         chk("fsr", 16'(exp_fsr(s)), 16'(fsr_mv));
         chk("sps", 16'(exp_sps(s)), 16'(rate_sps));
         rd(`PTR_CONFIG, word);
         chk("setup", {1'b1, s, s, 1'b1, s, 5'h03}, word);
      end
      core_val <= 16'h0123;
      wr(`PTR_CONFIG, 16'h8583);
      for (k = 0; k < 3 && conv_start !== 1'b1; k++) cyc(1);
      chk("start", 16'h0001, 16'(conv_start));
      chk("run", 16'h0001, 16'(conv_run));
      rd(`PTR_CONFIG, word);
      chk("busy", 16'h0000, 16'(word[15]));
      cyc(120);
      rd(`PTR_CONFIG, word);
      chk("idle", 16'h8583, word);
      rd(`PTR_RESULT, word);
      chk("result", 16'h0123, word);
      wr(`PTR_LOWER, 16'hff00);
      wr(`PTR_UPPER, 16'h0100);
      core_val <= 16'h0000;
      wcfg(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
      ex(16'h0000, 60, 1'b0, 1'b0);
      ex(hi_val, 60, 1'b1, 1'b0);
      ex(16'h0000, 60, 1'b1, 1'b0);
      ex(lo_val, 60, 1'b0, 1'b0);
      wcfg(1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
      ex(lo_val, 60, 1'b1, 1'b0);
      ex(16'h0000, 60, 1'b0, 1'b0);
      wcfg(1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
      ex(hi_val, 60, 1'b1, 1'b1);
      ex(16'h0000, 60, 1'b0, 1'b1);
      wcfg(1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
      ex(hi_val, 20, 1'b0, 1'b0);
      ex(hi_val, 80, 1'b1, 1'b0);
      wcfg(1'b0, 1'b1, 1'b0, 1'b1, 2'h0);
      ex(16'h0000, 60, 1'b1, 1'b0);
      rd(`PTR_RESULT, word);
      ex(16'h0000, 5, 1'b0, 1'b0);
      ex(hi_val, 60, 1'b1, 1'b0);
      ex(16'h0000, 60, 1'b1, 1'b0);
      @(posedge mclk);
      ara_req <= 1'b1;
      @(posedge mclk);
      ara_req <= 1'b0;
      #1;
      for (k = 0; k < 2 && ara_ack !== 1'b1; k++) cyc(1);
      chk("ara_ack", 16'h0001, 16'(ara_ack));
      chk("ara_addr", 16'(dev_addr), 16'(ara_addr));
      @(posedge mclk);
      ara_won <= 1'b1;
      @(posedge mclk);
      ara_won <= 1'b0;
      ex(16'h0000, 5, 1'b0, 1'b0);
      wcfg(1'b0, 1'b0, 1'b0, 1'b0, 2'h3);
      cyc(5);
      chk("oe_off", 16'h0001, 16'(alert_oe_n));
      wr(`PTR_LOWER, 16'h0000);
      wr(`PTR_UPPER, 16'h8000);
      wcfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
      ex(16'h0000, 150, 1'b1, 1'b0);
      wr(`PTR_CONFIG, 16'h8580);
      cyc(2);
      chk("rdy_busy", 16'h0001, 16'(alert_o));
      ex(16'h0000, 100, 1'b1, 1'b0);
      summarize();
   end
endmodule
